// File: design/sppi_params.svh
`ifndef SPPI_PARAMS_SVH
`define SPPI_PARAMS_SVH
// Register index and byte address (index times four)
`define SPPI_REG_IDX 14'h1C17
`define SPPI_REG_ADDR 16'h705C
`define SPPI_ADDR_W 16
`define SPPI_DATA_W 32
`define SPPI_REG_W 16
// Field positions
`define SPPI_P0_LSB 0
`define SPPI_P1_LSB 8
`define SPPI_PINS 6
// Writable bits, reserved 15-14 and 7-6 masked
`define SPPI_WR_MASK 16'h3F3F
// Reset value: all pull-downs switched off
`define SPPI_RST_VAL 16'h3F3F
`endif

// File: design/sppi_pkg.sv
package sppi_pkg;
  typedef enum logic [0:0] {
    SPPI_IDLE = 1'b0,
    SPPI_ACK = 1'b1
  } sppi_bus_state_t;
endpackage

// File: design/sppi_cfg_word.sv
`timescale 1ns/1ns
`include "sppi_params.svh"
// Holds the inhibit word; stores only unmasked bits, reads back registered
module sppi_cfg_word
  import sppi_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [`SPPI_REG_W-1:0] wr_data,
  input wire logic [1:0] wr_be,
  output logic [`SPPI_REG_W-1:0] word_r
);
  logic [`SPPI_REG_W-1:0] word_nxt;

  // Byte-lane merge with reserved bits forced to zero
  always_comb
  begin
    word_nxt = word_r;
    if (wr_be[0])
      word_nxt[7:0] = wr_data[7:0];
    if (wr_be[1])
      word_nxt[15:8] = wr_data[15:8];
    word_nxt = word_nxt & `SPPI_WR_MASK;
  end

  // Storage
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      word_r <= `SPPI_RST_VAL;
    else if (ce && wr_en)
      word_r <= word_nxt;
  end
endmodule

// File: design/sppi_top.sv
// Local design decision: the Wishbone register port.
`timescale 1ns/1ns
`include "sppi_params.svh"
module sppi_top
  import sppi_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`SPPI_ADDR_W-1:0] wb_adr_i,
  input wire logic [`SPPI_DATA_W-1:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [`SPPI_DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [`SPPI_PINS-1:0] port0_pd_off_r,
  output logic [`SPPI_PINS-1:0] port1_pd_off_r
);
  sppi_bus_state_t state_r;
  logic [`SPPI_REG_W-1:0] word_r;
  logic req;
  logic hit;
  logic wr_en;

  // Reset word, indexable per pad bit
  localparam logic [`SPPI_REG_W-1:0] pad_rst_word = `SPPI_RST_VAL;

  // New request only when idle, so each access acks once
  assign req = wb_cyc_i && wb_stb_i && (state_r == SPPI_IDLE);
  assign hit = (wb_adr_i == `SPPI_REG_ADDR);
  assign wr_en = req && wb_we_i && hit;

  sppi_cfg_word u_word (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .wr_en(wr_en),
    .wr_data(wb_dat_i[`SPPI_REG_W-1:0]),
    .wr_be(wb_sel_i[1:0]),
    .word_r(word_r)
  );

  // Ack one cycle after request, then drop
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= SPPI_IDLE;
      wb_ack_o <= 1'b0;
    end
    else if (ce)
    begin
      unique case (state_r)
        SPPI_IDLE:
        begin
          wb_ack_o <= req;
          if (req)
            state_r <= SPPI_ACK;
        end
        SPPI_ACK:
        begin
          wb_ack_o <= 1'b0;
          state_r <= SPPI_IDLE;
        end
      endcase
    end
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      wb_dat_o <= 32'h0000_0000;
    else if (ce && req)
      wb_dat_o <= hit ? {16'h0000, word_pending()} : 32'h0000_0000;
  end

  // Stored word as a read returns it
  function automatic logic [`SPPI_REG_W-1:0] word_pending();
    word_pending = word_r;
  endfunction

  // Pad controls: 1 turns pull-down off, 0 keeps it on
  genvar i;
  generate
    for (i = 0; i < `SPPI_PINS; i++)
    begin : g_pad
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          port0_pd_off_r[i] <= pad_rst_word[`SPPI_P0_LSB + i];
          port1_pd_off_r[i] <= pad_rst_word[`SPPI_P1_LSB + i];
        end
        else if (ce)
        begin
          port0_pd_off_r[i] <= word_r[`SPPI_P0_LSB + i];
          port1_pd_off_r[i] <= word_r[`SPPI_P1_LSB + i];
        end
      end
    end
  endgenerate

  // Ack is a single pulse while the block runs
  a_ack_one_cycle: assert property (@(posedge clk) disable iff (!rst_b)
    (wb_ack_o && ce) |=> !wb_ack_o)
    else $error("ack held more than one cycle");

  // Every taken request is answered on the next edge
  a_ack_after_req: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && req) |=> wb_ack_o)
    else $error("request not acknowledged");

  // No ack without a taken request
  a_no_stray_ack: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && !req) |=> !wb_ack_o)
    else $error("ack without request");

  // Ack holds while the clock enable is low
  a_ack_frozen: assert property (@(posedge clk) disable iff (!rst_b)
    !ce |=> $stable(wb_ack_o))
    else $error("ack moved while frozen");

  // Unmapped addresses read zero
  a_miss_reads_zero: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && req && !hit) |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  // Read of the register returns the stored word
  a_read_value: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && req && hit && !wb_we_i) |=> wb_dat_o == {16'h0000, $past(word_r)})
    else $error("read data wrong");

  // Read data stands until the next taken request
  a_dat_held: assert property (@(posedge clk) disable iff (!rst_b)
    !(ce && req) |=> $stable(wb_dat_o))
    else $error("read data moved without request");

  // Upper half of the read data is always zero
  a_upper_zero: assert property (@(posedge clk) disable iff (!rst_b)
    wb_dat_o[`SPPI_DATA_W-1:`SPPI_REG_W] == 16'h0000)
    else $error("upper read data not zero");

  // Reserved bits never hold a one
  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_b)
    (word_r & ~`SPPI_WR_MASK) == 16'h0000)
    else $error("reserved bit set");

  // Low-lane write stores the port 0 field
  a_write_lands: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && wr_en && wb_sel_i[0]) |=>
      word_r[`SPPI_P0_LSB +: `SPPI_PINS] == $past(wb_dat_i[`SPPI_P0_LSB +: `SPPI_PINS]))
    else $error("port 0 field not stored");

  // High-lane write stores the port 1 field
  a_high_write_lands: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && wr_en && wb_sel_i[1]) |=>
      word_r[`SPPI_P1_LSB +: `SPPI_PINS] == $past(wb_dat_i[`SPPI_P1_LSB +: `SPPI_PINS]))
    else $error("port 1 field not stored");

  // Disabled low lane keeps the port 0 field
  a_low_lane_kept: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && wr_en && !wb_sel_i[0]) |=>
      $stable(word_r[`SPPI_P0_LSB +: `SPPI_PINS]))
    else $error("port 0 field changed by other lane");

  // Disabled high lane keeps the port 1 field
  a_high_lane_kept: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && wr_en && !wb_sel_i[1]) |=>
      $stable(word_r[`SPPI_P1_LSB +: `SPPI_PINS]))
    else $error("port 1 field changed by other lane");

  // Unmapped writes leave the register alone
  a_miss_no_write: assert property (@(posedge clk) disable iff (!rst_b)
    (req && !hit) |=> $stable(word_r))
    else $error("unmapped write changed register");

  // Reads leave the register alone
  a_read_no_write: assert property (@(posedge clk) disable iff (!rst_b)
    (req && !wb_we_i) |=> $stable(word_r))
    else $error("read changed register");

  // Stored word holds while the clock enable is low
  a_word_frozen: assert property (@(posedge clk) disable iff (!rst_b)
    !ce |=> $stable(word_r))
    else $error("register moved while frozen");

  // Port 0 pads copy their field one edge later
  a_port0_follow: assert property (@(posedge clk) disable iff (!rst_b)
    ce |=> port0_pd_off_r == $past(word_r[`SPPI_P0_LSB +: `SPPI_PINS]))
    else $error("port 0 control mismatch");

  // Port 1 pads copy their field one edge later
  a_port1_follow: assert property (@(posedge clk) disable iff (!rst_b)
    ce |=> port1_pd_off_r == $past(word_r[`SPPI_P1_LSB +: `SPPI_PINS]))
    else $error("port 1 control mismatch");

  // Pads hold while the clock enable is low
  a_pads_frozen: assert property (@(posedge clk) disable iff (!rst_b)
    !ce |=> $stable(port0_pd_off_r) && $stable(port1_pd_off_r))
    else $error("pads moved while frozen");

  // Low-lane write that sets port 0 pin 0
  sequence s_p0_set_write;
    ce && wr_en && wb_sel_i[0] && wb_dat_i[`SPPI_P0_LSB];
  endsequence

  // High-lane write that clears port 1 pin 0
  sequence s_p1_clear_write;
    ce && wr_en && wb_sel_i[1] && !wb_dat_i[`SPPI_P1_LSB];
  endsequence

  // Enabled edge at which the pads copy the stored word
  sequence s_pad_copy;
    ce;
  endsequence

  // A one written to an inhibit bit switches the pull-down off
  a_set_lands: assert property (@(posedge clk) disable iff (!rst_b)
    s_p0_set_write ##1 s_pad_copy |=> port0_pd_off_r[0])
    else $error("pull-down not switched off");

  // A zero written to an inhibit bit re-enables the pull-down
  a_clear_lands: assert property (@(posedge clk) disable iff (!rst_b)
    s_p1_clear_write ##1 s_pad_copy |=> !port1_pd_off_r[0])
    else $error("pull-down not re-enabled");
endmodule

// File: verification/sppi_tb.sv
`timescale 1ns/1ns
`include "sppi_params.svh"
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack;
  logic [5:0] pd0;
  logic [5:0] pd1;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  // Clock
  always #10 clk = ~clk;
  sppi_top u_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .port0_pd_off_r(pd0), .port1_pd_off_r(pd1));
  // Verdict and end of run
  task automatic stop_test;
    if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      miscompares++;
      stop_test;
    end
  end
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // Classic single cycle, held until ack is sampled high at a rising edge
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
    input logic [3:0] s);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do
      @(posedge clk);
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_reset;
    bus(1'b0, `SPPI_REG_ADDR, 32'h0, 4'hF);
    check("reset word", 32'h0000_3F3F, q);
    check("reset pads", 32'h0000_0FFF, {pd1, pd0});
  endtask
  task automatic t_fields;
    bus(1'b1, `SPPI_REG_ADDR, 32'hFFFF_C2C1, 4'hF);
    bus(1'b0, `SPPI_REG_ADDR, 32'h0, 4'hF);
    check("masked word", 32'h0000_0201, q);
    check("port0 pads", 32'h0000_0001, pd0);
    check("port1 pads", 32'h0000_0002, pd1);
  endtask
  task automatic t_lanes;
    bus(1'b1, `SPPI_REG_ADDR, 32'hFFFF_FFFF, 4'h1);
    bus(1'b0, `SPPI_REG_ADDR, 32'h0, 4'hF);
    check("low lane", 32'h0000_023F, q);
    check("lane pads", 32'h0000_00BF, {pd1, pd0});
  endtask
  task automatic t_unmapped;
    bus(1'b1, `SPPI_REG_ADDR + 16'h0004, 32'h0, 4'hF);
    bus(1'b0, `SPPI_REG_ADDR + 16'h0004, 32'h0, 4'hF);
    check("unmapped read", 32'h0, q);
    bus(1'b0, `SPPI_REG_ADDR, 32'h0, 4'hF);
    check("kept word", 32'h0000_023F, q);
  endtask
  // Clock enable low: request waits, ack and pads hold
  task automatic t_freeze;
    ce <= 1'b0;
    cyc <= 1'b1;
    we <= 1'b1;
    adr <= `SPPI_REG_ADDR;
    wdat <= 32'h0000_0000;
    sel <= 4'h2;
    repeat (3) @(posedge clk);
    check("frozen ack", 32'h0, ack);
    check("frozen pads", 32'h0000_00BF, {pd1, pd0});
    ce <= 1'b1;
    do
      @(posedge clk);
    while (ack !== 1'b1);
    cyc <= 1'b0;
    @(posedge clk);
    check("thawed pads", 32'h0000_003F, {pd1, pd0});
  endtask
  // Reset in mid-run restores word and pads
  task automatic t_midreset;
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check("mid-reset pads", 32'h0000_0FFF, {pd1, pd0});
    bus(1'b0, `SPPI_REG_ADDR, 32'h0, 4'hF);
    check("mid-reset word", 32'h0000_3F3F, q);
  endtask
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset;
    t_fields;
    t_lanes;
    t_unmapped;
    t_freeze;
    t_midreset;
    stop_test;
  end
endmodule
